// ---- design/axis_pkg.sv ----
// Package with register map, field layouts, reset values and timing constants
package axis_pkg;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL       = 8'h00;
	localparam logic [7:0] OFS_STATUS     = 8'h04;
	localparam logic [7:0] OFS_SCALE      = 8'h08;
	localparam logic [7:0] OFS_VIB        = 8'h0c;
	localparam logic [7:0] OFS_CMP_ONE    = 8'h10;
	localparam logic [7:0] OFS_CMP_TWO    = 8'h14;
	localparam logic [7:0] OFS_MOTOR_POS  = 8'h18;
	localparam logic [7:0] OFS_ENC_CNT    = 8'h1c;
	localparam logic [7:0] OFS_POS_REF    = 8'h20;
	localparam logic [7:0] OFS_MOTOR_CAP  = 8'h24;
	localparam logic [7:0] OFS_MASTER_CAP = 8'h28;
	localparam logic [7:0] OFS_MOD_LEN    = 8'h2c;
	localparam logic [7:0] OFS_TOGGLE_ONE = 8'h30;
	localparam logic [7:0] OFS_TOGGLE_TWO = 8'h34;
	localparam logic [7:0] OFS_MOD_POS    = 8'h38;
	localparam logic [7:0] OFS_MOD_OFFSET = 8'h3c;
	// Control register bit positions
	localparam int BIT_FBK_A      = 0;
	localparam int BIT_FBK_B      = 1;
	localparam int BIT_SW_EN      = 2;
	localparam int BIT_PHASE_ONE  = 3;
	localparam int BIT_PHASE_TWO  = 4;
	localparam int BIT_CMP1_SRC   = 5;
	localparam int BIT_CMP2_SRC   = 6;
	localparam int BIT_MCAP_SRC   = 7;
	localparam int BIT_MOD_EN     = 8;
	localparam int BIT_MOD_STATE  = 9;
	localparam int BIT_UV_AUTO    = 10;
	localparam int BIT_VIB_SAVE   = 11;
	// Status register bit positions (write one clears sticky flags)
	localparam int BIT_CMP1_FLAG  = 0;
	localparam int BIT_CMP2_FLAG  = 1;
	localparam int BIT_MOTOR_CAP  = 2;
	localparam int BIT_MASTER_CAP = 3;
	localparam int BIT_PHASE_OK   = 4;
	localparam int BIT_READY      = 5;
	localparam int BIT_UV_ALARM   = 6;
	localparam int BIT_BUSY       = 7;
	localparam int STAT_CODE_LSB  = 8;
	// Phasing status codes
	localparam logic [3:0] PH_SUCCESS     = 4'h0;
	localparam logic [3:0] PH_WRONG_EN    = 4'h2;
	localparam logic [3:0] PH_POS_FBK     = 4'h3;
	localparam logic [3:0] PH_WRONG_POLES = 4'h4;
	localparam logic [3:0] PH_NOT_READY   = 4'h5;
	localparam logic [3:0] PH_VIB_DRIFT   = 4'h6;
	localparam logic [3:0] PH_VIB_MAX     = 4'h7;
	localparam logic [3:0] PH_NONE        = 4'hf;
	// Phasing limits
	localparam logic [15:0] VIB_DRIFT_LIM = 16'h0019;
	localparam logic [15:0] VIB_MAX       = 16'h00c8;
	localparam logic [15:0] VIB_DEFAULT   = 16'h0064;
	localparam logic [15:0] POLE_TOL      = 16'h00e1;
	// Reset values
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
	localparam logic [31:0] SCALE_RESET = 32'h0001_0001;
	localparam logic [31:0] SCALE_PRODUCT = 32'h0001_0000;
	// Timing
	localparam real CLK_MHZ      = 250.0;
	localparam real CMP_PERIOD_US = 6144.0;
	localparam real MOD_PERIOD_US = 512.0;
	localparam int CMP_CYCLES = int'($floor(CMP_PERIOD_US * CLK_MHZ));
	localparam int MOD_CYCLES = int'($floor(MOD_PERIOD_US * CLK_MHZ));
	localparam int PHASE_CYCLES = 8;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic        encoder_feedback;
		logic        software_enable;
		logic        hardware_enable;
		logic [15:0] drive_fault_code;
	} phase_cond_t;
endpackage

// ---- design/encoder_phasing_compare_capture.sv ----
// Encoder phasing, value comparators, position capture and modulo output
`timescale 1ns/1ps
// What this block does
// - Phasing is lost at every start-up; ready needs a new phasing.
// - Phasing one accepted only with software off, hardware on, fault zero.
// - Phasing two checks the same preconditions, then does a vibration.
// - Status codes 0,2,3,4,5 after phasing one; pole tolerance 22.5 degrees.
// - Phasing two reports 6 on drift of 25, 7 above 200.
// - Phasing ok flag set only on success; needed for drive ready.
// - Multiplier over divider times four times pulses equals 65536; signed. The scale word is only stored, never checked.
// - A saved vibration frequency seeds phasing two at the next start-up.
// - Comparator one source zero: flag when threshold exceeds motor position.
// - Comparator one source one: flag when threshold exceeds reference.
// - Comparator two behaves the same with its own threshold and source.
// - Both comparators are evaluated every 6.144 ms.
// - Unused comparator words and source bits stay read-write storage.
// - Rising edge of input one captures motor position and sets flag.
// - Motor-captured flag stays set until software clears it.
// - Master capture edge copies encoder counter and sets its flag.
// - Master source select: zero picks input zero, one picks zero track.
// - Output one inverts when a step crosses one toggle point; crossing both in one step leaves it.
// - Enabled modulo function starts from programmed position and state.
// - Offset word is added to the tracked modulo position.
// - Modulo output is recomputed every 512 microseconds.
// - With auto-clear set, undervoltage alarm clears when supply returns.
module encoder_phasing_compare_capture (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Drive state from the surrounding logic
	input  wire logic        hardware_enable,
	input  wire logic [15:0] drive_fault_code,
	input  wire logic        supply_ok,
	input  wire logic        undervoltage_event,
	input  wire logic [31:0] motor_position,
	input  wire logic [31:0] encoder_in_counter,
	input  wire logic [31:0] position_reference,
	// Phasing measurements from the motion engine
	input  wire logic        phase_done,
	input  wire logic        phase_pos_fbk,
	input  wire logic [15:0] phase_pole_err,
	input  wire logic [15:0] phase_vib_result,
	// Pins from outside the clock domain
	input  wire logic        digital_input_one,
	input  wire logic        digital_input_zero,
	input  wire logic        encoder_zero_track,
	// Outputs
	output logic             phase_request,
	output logic             phase_vibration,
	output logic [15:0]      phase_vib_start,
	output logic             drive_ready_flag,
	output logic             digital_output_one
);
	logic [31:0] ctrl_reg;
	logic [31:0] scale_reg;
	logic [15:0] vibration_frequency;
	// Power-on value only; a reset of the drive leaves the saved seed alone
	logic [15:0] vib_saved_reg = axis_pkg::VIB_DEFAULT;
	logic [31:0] cmp_one_threshold;
	logic [31:0] cmp_two_threshold;
	logic [31:0] motor_capture_value;
	logic [31:0] master_capture_value;
	logic [31:0] modulo_length;
	logic [31:0] toggle_point_one;
	logic [31:0] toggle_point_two;
	logic [31:0] modulo_position;
	logic [31:0] modulo_offset;
	logic        cmp_one_flag;
	logic        cmp_two_flag;
	logic        motor_captured_flag;
	logic        master_captured_flag;
	logic        phasing_ok_flag;
	logic        uv_alarm_reg;
	logic [3:0]  phasing_status;
	logic        modulo_output_state;
	logic [31:0] last_motor_reg;
	logic        mod_run_reg;
	// Synchronisers: index 0 first stage, 1 second, 2 history for edges
	logic [2:0]  sync_reg [3];
	logic [2:0]  pin_in;
	logic        wr_en;
	logic        rd_en;
	logic        feedback_select_a;
	logic        feedback_select_b;
	logic        enc_fbk;
	logic [31:0] fbk_pos;
	logic        din1_rise;
	logic        master_edge;
	logic        conds_ok;
	logic [23:0] cmp_cnt_reg;
	logic [19:0] mod_cnt_reg;
	logic        cmp_tick;
	logic        mod_tick;
	logic [31:0] status_word;

	typedef enum logic [1:0] {PH_IDLE, PH_RUN_ONE, PH_RUN_TWO} phase_state_t;
	phase_state_t phase_state;

	assign pin_in = {encoder_zero_track, digital_input_zero, digital_input_one};
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = psel && penable;
	assign feedback_select_a = ctrl_reg[axis_pkg::BIT_FBK_A];
	assign feedback_select_b = ctrl_reg[axis_pkg::BIT_FBK_B];
	// Encoder feedback only with a set and b clear
	assign enc_fbk = feedback_select_a && !feedback_select_b;
	assign fbk_pos = enc_fbk ? encoder_in_counter : motor_position;

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge sys_clk) begin
				if (rst)
					sync_reg[gi] <= 3'h0;
				else
					sync_reg[gi] <= {sync_reg[gi][1:0], pin_in[gi]};
			end
		end
	endgenerate

	assign din1_rise = sync_reg[0][1] && !sync_reg[0][2];
	assign master_edge = ctrl_reg[axis_pkg::BIT_MCAP_SRC] ?
		(sync_reg[2][1] && !sync_reg[2][2]) :
		(sync_reg[1][1] && !sync_reg[1][2]);

	assign conds_ok = !ctrl_reg[axis_pkg::BIT_SW_EN] && hardware_enable;
	assign drive_ready_flag = phasing_ok_flag && !uv_alarm_reg;

	// Periodic ticks
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmp_cnt_reg <= 24'h0;
			mod_cnt_reg <= 20'h0;
		end else begin
			cmp_cnt_reg <= cmp_tick ? 24'h0 : cmp_cnt_reg + 24'h1;
			mod_cnt_reg <= mod_tick ? 20'h0 : mod_cnt_reg + 20'h1;
		end
	end
	assign cmp_tick = cmp_cnt_reg == 24'(axis_pkg::CMP_CYCLES - 1);
	assign mod_tick = mod_cnt_reg == 20'(axis_pkg::MOD_CYCLES - 1);

	// Control and storage words, read-write; the phasing command bits clear themselves once seen in idle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl_reg <= axis_pkg::CTRL_RESET;
			scale_reg <= axis_pkg::SCALE_RESET;
			cmp_one_threshold <= 32'h0;
			cmp_two_threshold <= 32'h0;
			modulo_length <= 32'h0;
			toggle_point_one <= 32'h0;
			toggle_point_two <= 32'h0;
			modulo_offset <= 32'h0;
		end else begin
			if (phase_state == PH_IDLE && ctrl_reg[axis_pkg::BIT_PHASE_ONE])
				ctrl_reg[axis_pkg::BIT_PHASE_ONE] <= 1'b0;
			if (phase_state == PH_IDLE && ctrl_reg[axis_pkg::BIT_PHASE_TWO])
				ctrl_reg[axis_pkg::BIT_PHASE_TWO] <= 1'b0;
			if (wr_en) begin
				case (paddr)
				axis_pkg::OFS_CTRL:       ctrl_reg <= pwdata;
				axis_pkg::OFS_SCALE:      scale_reg <= pwdata;
				axis_pkg::OFS_CMP_ONE:    cmp_one_threshold <= pwdata;
				axis_pkg::OFS_CMP_TWO:    cmp_two_threshold <= pwdata;
				axis_pkg::OFS_MOD_LEN:    modulo_length <= pwdata;
				axis_pkg::OFS_TOGGLE_ONE: toggle_point_one <= pwdata;
				axis_pkg::OFS_TOGGLE_TWO: toggle_point_two <= pwdata;
				axis_pkg::OFS_MOD_OFFSET: modulo_offset <= pwdata;
				default: ;
				endcase
			end
		end
	end

	// No reset here: the saved seed must outlive a restart of the drive
	always_ff @(posedge sys_clk) begin
		if (ctrl_reg[axis_pkg::BIT_VIB_SAVE])
			vib_saved_reg <= vibration_frequency;
	end

	// Phasing sequencer; phasing two is seeded from the saved copy
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			phase_state <= PH_IDLE;
			phasing_status <= axis_pkg::PH_NONE;
			phasing_ok_flag <= 1'b0;
			vibration_frequency <= axis_pkg::VIB_DEFAULT;
		end else begin
			case (phase_state)
			PH_IDLE: begin
				if (ctrl_reg[axis_pkg::BIT_PHASE_ONE] ||
				    ctrl_reg[axis_pkg::BIT_PHASE_TWO]) begin
					phasing_ok_flag <= 1'b0;
					if (!conds_ok) begin
						phasing_status <= axis_pkg::PH_WRONG_EN;
					end else if (drive_fault_code != 16'h0) begin
						phasing_status <= axis_pkg::PH_NOT_READY;
					end else if (ctrl_reg[axis_pkg::BIT_PHASE_ONE]) begin
						phase_state <= PH_RUN_ONE;
					end else begin
						vibration_frequency <= vib_saved_reg;
						phase_state <= PH_RUN_TWO;
					end
				end
			end
			PH_RUN_ONE: begin
				if (phase_done) begin
					phase_state <= PH_IDLE;
					if (phase_pos_fbk) begin
						phasing_status <= axis_pkg::PH_POS_FBK;
					end else if ($signed(phase_pole_err) >
					             $signed(axis_pkg::POLE_TOL) ||
					             $signed(phase_pole_err) <
					             -$signed(axis_pkg::POLE_TOL)) begin
						phasing_status <= axis_pkg::PH_WRONG_POLES;
					end else begin
						phasing_status <= axis_pkg::PH_SUCCESS;
						phasing_ok_flag <= 1'b1;
					end
				end
			end
			PH_RUN_TWO: begin
				if (phase_done) begin
					phase_state <= PH_IDLE;
					vibration_frequency <= phase_vib_result;
					if (phase_vib_result > axis_pkg::VIB_MAX) begin
						phasing_status <= axis_pkg::PH_VIB_MAX;
					end else if (phase_vib_result >=
					             vibration_frequency + axis_pkg::VIB_DRIFT_LIM ||
					             vibration_frequency >=
					             phase_vib_result + axis_pkg::VIB_DRIFT_LIM) begin
						phasing_status <= axis_pkg::PH_VIB_DRIFT;
					end else begin
						phasing_status <= axis_pkg::PH_SUCCESS;
						phasing_ok_flag <= 1'b1;
					end
				end
			end
			default: phase_state <= PH_IDLE;
			endcase
		end
	end
	assign phase_request = phase_state != PH_IDLE;
	assign phase_vibration = phase_state == PH_RUN_TWO;
	assign phase_vib_start = vibration_frequency;

	// Comparators sampled on the periodic tick
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmp_one_flag <= 1'b0;
			cmp_two_flag <= 1'b0;
		end else if (cmp_tick) begin
			cmp_one_flag <= $signed(cmp_one_threshold) >
				$signed(ctrl_reg[axis_pkg::BIT_CMP1_SRC] ?
				position_reference : fbk_pos);
			cmp_two_flag <= $signed(cmp_two_threshold) >
				$signed(ctrl_reg[axis_pkg::BIT_CMP2_SRC] ?
				position_reference : fbk_pos);
		end
	end

	// Captures; a new edge wins over a clear in the same cycle
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			motor_capture_value <= 32'h0;
			master_capture_value <= 32'h0;
			motor_captured_flag <= 1'b0;
			master_captured_flag <= 1'b0;
		end else begin
			if (wr_en && paddr == axis_pkg::OFS_STATUS) begin
				if (pwdata[axis_pkg::BIT_MOTOR_CAP])
					motor_captured_flag <= 1'b0;
				if (pwdata[axis_pkg::BIT_MASTER_CAP])
					master_captured_flag <= 1'b0;
			end
			if (din1_rise) begin
				motor_capture_value <= fbk_pos;
				motor_captured_flag <= 1'b1;
			end
			if (master_edge) begin
				master_capture_value <= encoder_in_counter;
				master_captured_flag <= 1'b1;
			end
		end
	end

	// Undervoltage alarm
	always_ff @(posedge sys_clk) begin
		if (rst)
			uv_alarm_reg <= 1'b0;
		else if (undervoltage_event)
			uv_alarm_reg <= 1'b1;
		else if (supply_ok && ctrl_reg[axis_pkg::BIT_UV_AUTO])
			uv_alarm_reg <= 1'b0;
		else if (wr_en && paddr == axis_pkg::OFS_STATUS &&
		         pwdata[axis_pkg::BIT_UV_ALARM])
			uv_alarm_reg <= 1'b0;
	end

	// Modulo output; one step of motion per 512 us is assumed below modulus
	logic [31:0] delta;
	logic [31:0] pos_sum;
	logic [31:0] pos_wrap;
	logic [31:0] eff_old;
	logic [31:0] eff_new;
	logic        cross_one;
	logic        cross_two;
	always_comb begin
		delta = fbk_pos - last_motor_reg;
		pos_sum = modulo_position + delta;
		if ($signed(pos_sum) < 0)
			pos_wrap = pos_sum + modulo_length;
		else if ($signed(pos_sum) >= $signed(modulo_length))
			pos_wrap = pos_sum - modulo_length;
		else
			pos_wrap = pos_sum;
		eff_old = modulo_position + modulo_offset;
		eff_new = pos_wrap + modulo_offset;
		cross_one = ($signed(eff_old) < $signed(toggle_point_one)) !=
			($signed(eff_new) < $signed(toggle_point_one));
		cross_two = ($signed(eff_old) < $signed(toggle_point_two)) !=
			($signed(eff_new) < $signed(toggle_point_two));
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			modulo_position <= 32'h0;
			modulo_output_state <= 1'b0;
			last_motor_reg <= 32'h0;
			mod_run_reg <= 1'b0;
		end else if (!ctrl_reg[axis_pkg::BIT_MOD_EN]) begin
			mod_run_reg <= 1'b0;
			last_motor_reg <= fbk_pos;
			if (wr_en && paddr == axis_pkg::OFS_MOD_POS)
				modulo_position <= pwdata;
			modulo_output_state <= ctrl_reg[axis_pkg::BIT_MOD_STATE];
		end else if (!mod_run_reg) begin
			mod_run_reg <= 1'b1;
			last_motor_reg <= fbk_pos;
		end else if (mod_tick) begin
			last_motor_reg <= fbk_pos;
			modulo_position <= pos_wrap;
			if (cross_one ^ cross_two)
				modulo_output_state <= !modulo_output_state;
		end
	end
	assign digital_output_one = modulo_output_state;

	// Read mux
	always_comb begin
		status_word = 32'h0;
		status_word[axis_pkg::BIT_CMP1_FLAG] = cmp_one_flag;
		status_word[axis_pkg::BIT_CMP2_FLAG] = cmp_two_flag;
		status_word[axis_pkg::BIT_MOTOR_CAP] = motor_captured_flag;
		status_word[axis_pkg::BIT_MASTER_CAP] = master_captured_flag;
		status_word[axis_pkg::BIT_PHASE_OK] = phasing_ok_flag;
		status_word[axis_pkg::BIT_READY] = drive_ready_flag;
		status_word[axis_pkg::BIT_UV_ALARM] = uv_alarm_reg;
		status_word[axis_pkg::BIT_BUSY] = phase_request;
		status_word[axis_pkg::STAT_CODE_LSB +: 4] = phasing_status;
		pslverr = 1'b0;
		case (paddr)
		axis_pkg::OFS_CTRL:       prdata = ctrl_reg;
		axis_pkg::OFS_STATUS:     prdata = status_word;
		axis_pkg::OFS_SCALE:      prdata = scale_reg;
		axis_pkg::OFS_VIB:        prdata = {16'h0, vibration_frequency};
		axis_pkg::OFS_CMP_ONE:    prdata = cmp_one_threshold;
		axis_pkg::OFS_CMP_TWO:    prdata = cmp_two_threshold;
		axis_pkg::OFS_MOTOR_POS:  prdata = motor_position;
		axis_pkg::OFS_ENC_CNT:    prdata = encoder_in_counter;
		axis_pkg::OFS_POS_REF:    prdata = position_reference;
		axis_pkg::OFS_MOTOR_CAP:  prdata = motor_capture_value;
		axis_pkg::OFS_MASTER_CAP: prdata = master_capture_value;
		axis_pkg::OFS_MOD_LEN:    prdata = modulo_length;
		axis_pkg::OFS_TOGGLE_ONE: prdata = toggle_point_one;
		axis_pkg::OFS_TOGGLE_TWO: prdata = toggle_point_two;
		axis_pkg::OFS_MOD_POS:    prdata = modulo_position;
		axis_pkg::OFS_MOD_OFFSET: prdata = modulo_offset;
		default: begin
			prdata = 32'h0;
			pslverr = rd_en || wr_en;
		end
		endcase
	end

	// Checks
	a_capture_sets_flag: assert property (@(posedge sys_clk) disable iff (rst)
		din1_rise |=> motor_captured_flag)
		else $error("motor capture flag not set");
	a_flag_stays_set: assert property (@(posedge sys_clk) disable iff (rst)
		motor_captured_flag && !(wr_en && paddr == axis_pkg::OFS_STATUS)
		|=> motor_captured_flag)
		else $error("motor capture flag dropped");
	a_master_capture_copy: assert property (@(posedge sys_clk)
		disable iff (rst) master_edge |=>
		master_capture_value == $past(encoder_in_counter))
		else $error("master capture value wrong");
	a_ok_only_success: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(phasing_ok_flag) |-> phasing_status == axis_pkg::PH_SUCCESS)
		else $error("phasing ok without success");
	a_wrong_enable_code: assert property (@(posedge sys_clk)
		disable iff (rst) phase_state == PH_IDLE &&
		ctrl_reg[axis_pkg::BIT_PHASE_ONE] && !conds_ok
		|=> phasing_status == axis_pkg::PH_WRONG_EN && !phase_request)
		else $error("wrong enabling not reported");
	a_cmp_only_tick: assert property (@(posedge sys_clk) disable iff (rst)
		!$past(cmp_tick) |-> $stable(cmp_one_flag))
		else $error("comparator changed off tick");
	a_mod_out_tick: assert property (@(posedge sys_clk) disable iff (rst)
		mod_run_reg && $past(mod_run_reg) && !$past(mod_tick)
		|-> $stable(digital_output_one))
		else $error("modulo output changed off tick");
	a_ready_needs_ok: assert property (@(posedge sys_clk) disable iff (rst)
		drive_ready_flag |-> phasing_ok_flag)
		else $error("ready without phasing");
endmodule

// ---- verif/phase_partner.sv ----
// Motion engine model that answers phasing requests
`timescale 1ns/1ps
module phase_partner (
	// Clock
	input  wire logic        sys_clk,
	// Request from the block
	input  wire logic        phase_request,
	// Results chosen by the bench
	input  wire logic        res_fbk,
	input  wire logic [15:0] res_pole,
	input  wire logic [15:0] res_vib,
	// Answers
	output logic             phase_done,
	output logic             phase_pos_fbk,
	output logic [15:0]      phase_pole_err,
	output logic [15:0]      phase_vib_result
);
	logic [15:0] cnt = 16'h0000;
	logic        hit;
	assign hit = phase_request && cnt == 16'h0014;
	// Slow answer; results are junk outside the done cycle
	always @(posedge sys_clk) begin
		cnt <= phase_request ? cnt + 16'h0001 : 16'h0000;
		phase_done <= hit;
		phase_pos_fbk <= hit ? res_fbk : cnt[0];
		phase_pole_err <= hit ? res_pole : cnt ^ 16'ha5a5;
		phase_vib_result <= hit ? res_vib : ~cnt;
	end
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the axis position block
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, done, pfbk, preq, pvib, ready, dout;
	logic        hw_en = 1;
	logic        uv = 0;
	logic        sup = 1;
	logic        fbk = 0;
	logic [15:0] flt = 0;
	logic [15:0] pole = 0;
	logic [15:0] vib = 0;
	logic [15:0] perr, vres, vstart;
	logic [31:0] enc = 0;
	logic [2:0]  pins = 0;
	int          n_errors = 0;
	int          n_tests = 0;
	logic [31:0] cmds [9] = '{'hd,'h9,'h9,'h11,'h11,'h9,'h9,'h9,'h11};
	logic [15:0] vibs [9] = '{'h64,'h64,'h64,'h7d,'hfa,'h64,'h64,'h64,'h6e};
	logic [15:0] poles [9] = '{0,0,0,0,0,0,'h12c,'he1,0};
	logic [3:0]  codes [9] = '{2,2,5,6,7,3,4,0,0};

	always #2 sys_clk = ~sys_clk;

	encoder_phasing_compare_capture encoder_phasing_compare_capture_i (
		.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .hardware_enable(hw_en),
		.drive_fault_code(flt), .supply_ok(sup), .undervoltage_event(uv),
		.motor_position(32'h0), .encoder_in_counter(enc),
		.position_reference(32'h0), .phase_done(done), .phase_pos_fbk(pfbk),
		.phase_pole_err(perr), .phase_vib_result(vres),
		.digital_input_one(pins[0]), .digital_input_zero(pins[1]),
		.encoder_zero_track(pins[2]), .phase_request(preq),
		.phase_vibration(pvib), .phase_vib_start(vstart),
		.drive_ready_flag(ready), .digital_output_one(dout));
	phase_partner phase_partner_i (
		.sys_clk(sys_clk), .phase_request(preq), .res_fbk(fbk),
		.res_pole(pole), .res_vib(vib), .phase_done(done),
		.phase_pos_fbk(pfbk), .phase_pole_err(perr),
		.phase_vib_result(vres));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("errors %0d checks %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// APB cycle; holds the request until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1;
		for (i = 0; i < 50; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
		if (i == 50) begin
			n_errors++;
			report_and_stop;
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e);
		xfer(0, a, 0);
		check(rd & m, e);
	endtask
	task automatic phase(input logic [31:0] c);
		int i;
		xfer(1, axis_pkg::OFS_CTRL, c);
		for (i = 0; i < 100; i++) begin
			xfer(0, axis_pkg::OFS_STATUS, 0);
			if (preq === 1'b1)
				check(pvib, c[axis_pkg::BIT_PHASE_TWO]);
			if (rd[axis_pkg::BIT_BUSY] === 1'b0)
				break;
		end
		check(i < 100, 1);
	endtask
	// Pins are synchronised, so each level is held for several cycles
	task automatic pulse(input int k);
		pins[k] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		pins[k] <= 1'b0;
		repeat (6) @(posedge sys_clk);
	endtask

	initial begin
		repeat (16) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		rchk(axis_pkg::OFS_CTRL, '1, axis_pkg::CTRL_RESET);
		rchk(axis_pkg::OFS_STATUS, 'hf30, 'hf00);
		rchk(axis_pkg::OFS_SCALE, '1, axis_pkg::SCALE_RESET);
		check(vstart, axis_pkg::VIB_DEFAULT);
		rchk(8'h40, '1, 0);
		check(err, 1);
		for (int k = 0; k < 9; k++) begin
			hw_en <= k != 1;
			flt <= k == 2;
			fbk <= k == 5;
			pole <= poles[k];
			vib <= vibs[k];
			phase(cmds[k]);
			check(rd & 'hf30, {codes[k], (codes[k] == 0) ? 8'h30 : 8'h0});
			check(ready, codes[k] == 0);
		end
		xfer(1, axis_pkg::OFS_CMP_ONE, 'h8000_0001);
		xfer(1, axis_pkg::OFS_CMP_TWO, 'h7fff_ffff);
		xfer(1, axis_pkg::OFS_CTRL, 'h61);
		rchk(axis_pkg::OFS_CMP_ONE, '1, 'h8000_0001);
		rchk(axis_pkg::OFS_CMP_TWO, '1, 'h7fff_ffff);
		rchk(axis_pkg::OFS_CTRL, 'h61, 'h61);
		enc <= 'h1234_5678;
		pulse(0);
		rchk(axis_pkg::OFS_MOTOR_CAP, '1, 'h1234_5678);
		enc <= 'h0bad_0001;
		xfer(1, axis_pkg::OFS_MOTOR_CAP, '1);
		repeat (20) @(posedge sys_clk);
		rchk(axis_pkg::OFS_MOTOR_CAP, '1, 'h1234_5678);
		rchk(axis_pkg::OFS_STATUS, 'h4, 'h4);
		xfer(1, axis_pkg::OFS_STATUS, 'h4);
		rchk(axis_pkg::OFS_STATUS, 'h4, 0);
		for (int s = 0; s < 2; s++) begin
			xfer(1, axis_pkg::OFS_CTRL, 'h1 | (s << 7));
			enc <= 'h100 + s;
			pulse(2 - s);
			rchk(axis_pkg::OFS_STATUS, 'h8, 0);
			pulse(1 + s);
			rchk(axis_pkg::OFS_MASTER_CAP, '1, 'h100 + s);
			rchk(axis_pkg::OFS_STATUS, 'h8, 'h8);
			xfer(1, axis_pkg::OFS_STATUS, 'h8);
		end
		// Modulo output held off, then enabled from the programmed start
		xfer(1, axis_pkg::OFS_MOD_LEN, 'h100);
		xfer(1, axis_pkg::OFS_TOGGLE_ONE, 'h20);
		xfer(1, axis_pkg::OFS_TOGGLE_TWO, 'h60);
		xfer(1, axis_pkg::OFS_MOD_POS, 'h10);
		check(dout, 0);
		xfer(1, axis_pkg::OFS_CTRL, 'h201);
		@(posedge sys_clk);
		check(dout, 1);
		xfer(1, axis_pkg::OFS_CTRL, 'h301);
		repeat (8) @(posedge sys_clk);
		check(dout, 1);
		rchk(axis_pkg::OFS_MOD_POS, '1, 'h10);
		rchk(axis_pkg::OFS_TOGGLE_TWO, '1, 'h60);
		// Undervoltage stays until auto clear is on and supply is back
		sup <= 0;
		uv <= 1;
		@(posedge sys_clk);
		uv <= 0;
		sup <= 1;
		rchk(axis_pkg::OFS_STATUS, 'h60, 'h40);
		check(ready, 0);
		xfer(1, axis_pkg::OFS_CTRL, 'hc01);
		rchk(axis_pkg::OFS_STATUS, 'h70, 'h30);
		// Restart: phasing is lost, the saved seed is kept
		rst <= 1;
		repeat (4) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		check(vstart, axis_pkg::VIB_DEFAULT);
		rchk(axis_pkg::OFS_STATUS, 'h10, 0);
		vib <= 'h82;
		phase('h11);
		check(rd & 'hf30, 'h030);
		report_and_stop;
	end
endmodule
